// ===== dv/fpr_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpr_flash_model (
  input wire logic clk,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic byte_n,
  input wire logic [18:0] addr,
  input wire logic a_lsb,
  output logic [15:0] dq,
  output logic rb
);
  logic tog = 0;
  logic [15:0] w;
  int busy = 0;
  // Released lanes toggle each cycle so stale data cannot pass
  always @(posedge clk) tog <= !tog;
  // Program ignores deselect; restore trims it but busy stays low
  always @(posedge clk) begin
    if (!reset_n && busy > 24) busy <= 24;
    else if (busy > 0) busy <= busy - 1;
    else if (!we_n && !ce_n && reset_n) busy <= 40;
  end
  assign rb = busy == 0;
  // Array read needs no command; data follows address at once
  always @* begin
    w = addr[15:0] ^ {addr[18:16], 13'h1A5B};
    dq = {16{tog}} ^ 16'h5A5A;
    if (!ce_n && !oe_n && reset_n) begin
      if (byte_n) dq = w;
      else dq[7:0] = a_lsb ? w[15:8] : w[7:0];
    end
  end
endmodule
`default_nettype wire

// ===== dv/fpr_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module fpr_host_bench;
  logic core_clk = 0, rst = 1, top_boot = 0, byte_mode = 0, req_valid = 0;
  logic req_write = 0, req_restore = 0, req_lsb = 0;
  logic [18:0] req_addr = 0, flash_addr_ff;
  logic [15:0] req_wdata = 0, flash_dq_in, dev_dq, flash_dq_out_ff;
  logic [15:0] rsp_rdata_ff;
  logic [4:0] rsp_sector_ff;
  logic req_ready, rsp_valid_ff, restore_done_ff, dev_busy_ff, flash_ce_n_ff;
  logic flash_oe_n_ff, flash_we_n_ff, flash_reset_n_ff, flash_byte_n_ff;
  logic flash_dq_oe_lo_ff, flash_dq_oe_hi_ff, ready_busy_out;
  int err_total = 0, num_checks = 0;
  fpr_host #(.READY_CYC(10)) fpr_host_inst (.core_clk(core_clk), .rst(rst),
    .top_boot(top_boot), .byte_mode(byte_mode), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write),
    .req_restore(req_restore), .req_addr(req_addr), .req_lsb(req_lsb),
    .req_wdata(req_wdata), .rsp_valid_ff(rsp_valid_ff),
    .rsp_rdata_ff(rsp_rdata_ff), .rsp_sector_ff(rsp_sector_ff),
    .restore_done_ff(restore_done_ff), .dev_busy_ff(dev_busy_ff),
    .flash_ce_n_ff(flash_ce_n_ff), .flash_oe_n_ff(flash_oe_n_ff),
    .flash_we_n_ff(flash_we_n_ff), .flash_reset_n_ff(flash_reset_n_ff),
    .flash_byte_n_ff(flash_byte_n_ff), .flash_addr_ff(flash_addr_ff),
    .flash_dq_in(flash_dq_in), .flash_dq_out_ff(flash_dq_out_ff),
    .flash_dq_oe_lo_ff(flash_dq_oe_lo_ff),
    .flash_dq_oe_hi_ff(flash_dq_oe_hi_ff), .ready_busy_out(ready_busy_out));
  fpr_flash_model fpr_flash_model_inst (.clk(core_clk), .ce_n(flash_ce_n_ff),
    .oe_n(flash_oe_n_ff), .we_n(flash_we_n_ff), .reset_n(flash_reset_n_ff),
    .byte_n(flash_byte_n_ff), .addr(flash_addr_ff),
    .a_lsb(flash_dq_out_ff[15]), .dq(dev_dq), .rb(ready_busy_out));
  // Shared data pins: whichever side enables a lane owns it
  assign flash_dq_in = {
    flash_dq_oe_hi_ff ? flash_dq_out_ff[15:8] : dev_dq[15:8],
    flash_dq_oe_lo_ff ? flash_dq_out_ff[7:0] : dev_dq[7:0]};
  initial forever #12.5 core_clk = !core_clk;
  function automatic logic [15:0] mem(logic [18:0] a);
    return a[15:0] ^ {a[18:16], 13'h1A5B};
  endfunction
  function automatic logic [4:0] sec(logic t, logic [18:0] a);
    if (t) return a[18:15] != 4'hF ? 5'(a[18:15]) : !a[14] ? 5'h0F :
      !a[13] ? 5'(5'h10 + a[12]) : 5'h12;
    return a[18:15] != 4'h0 ? 5'(a[18:15] + 5'h03) : a[14] ? 5'h03 :
      a[13] ? 5'(5'h01 + a[12]) : 5'h00;
  endfunction
  task automatic test_done;
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One request from idle, then wait for its completion sign
  task automatic req(logic w, logic r, logic [18:0] a);
    int i;
    logic [15:0] d;
    logic l;
    l = 1'($urandom);
    req_write = w;
    req_restore = r;
    req_addr = a;
    req_lsb = l;
    req_wdata = 16'($urandom);
    req_valid = 1;
    `CHK(req_ready, 1'b1)
    @(posedge core_clk);
    @(negedge core_clk);
    req_valid = 0;
    // Write pins must carry the request while the strobe is low
    if (w && !r) begin
      d = byte_mode ? {l, req_wdata[14:0]} : req_wdata;
      `CHK(flash_addr_ff, a)
      `CHK(flash_dq_out_ff, d)
    end
    for (i = 1; i <= 99; i++) begin
      @(negedge core_clk);
      if (r ? restore_done_ff : w ? req_ready : rsp_valid_ff) break;
    end
    if (i > 99) begin
      err_total++;
      test_done;
    end
    if (!w && !r) begin
      d = mem(a);
      if (byte_mode) d = {8'h00, l ? d[15:8] : d[7:0]};
      `CHK(rsp_rdata_ff, d)
      `CHK(rsp_sector_ff, sec(top_boot, a))
    end
  endtask
  initial begin
    int p, k;
    void'($urandom(32'hEA497B60));
    repeat (12) @(negedge core_clk);
    rst = 0;
    // Every sector row of both layouts, word and byte lanes
    for (p = 0; p < 4; p++) begin
      top_boot = p[0];
      byte_mode = p[1];
      repeat (3) @(negedge core_clk);
      for (k = 0; k < 128; k++) req(0, 0, {k[6:0], 12'($urandom)});
    end
    // Restore cuts a running program; read at once, then reprogram
    req(1, 0, 19'h12345);
    // Cut early, so busy outlasts the pulse and the wait is exercised
    repeat (2) @(negedge core_clk);
    `CHK(dev_busy_ff, 1'b1)
    req(0, 1, 19'h00000);
    req(0, 0, 19'h7FFFF);
    req(1, 0, 19'h12345);
    repeat (60) @(negedge core_clk);
    `CHK(dev_busy_ff, 1'b0)
    req(0, 1, 19'h00000);
    req(0, 0, 19'h00ABC);
    test_done;
  end
endmodule
`default_nettype wire

// ===== dv/fpr_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fpr_host_properties #(
  parameter READY_CYC = 800
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic req_restore,
  input wire logic rsp_valid_ff,
  input wire logic restore_done_ff,
  input wire logic flash_ce_n_ff,
  input wire logic flash_oe_n_ff,
  input wire logic flash_we_n_ff,
  input wire logic flash_reset_n_ff,
  input wire logic flash_dq_oe_lo_ff,
  input wire logic dev_busy_ff,
  input wire logic ready_busy_out
);
  localparam int DONE_MAX = READY_CYC + 30;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Accepted requests, split by kind
  wire rd_take = req_valid && req_ready && !req_write && !req_restore;
  wire rs_take = req_valid && req_ready && req_restore;
  a_read_strobes:
    assert property (rd_take |=> (!flash_ce_n_ff && !flash_oe_n_ff) [*4])
    else $error("read strobes cut short");
  a_read_answer:
    assert property (rd_take |-> ##6 rsp_valid_ff) else $error("no read data");
  a_gate_float:
    assert property (!flash_oe_n_ff |-> !flash_dq_oe_lo_ff && flash_we_n_ff)
    else $error("host drives while gated");
  a_restore_quiet:
    assert property (!flash_reset_n_ff |-> flash_oe_n_ff && flash_we_n_ff)
    else $error("cycle during restore");
  a_restore_width:
    assert property ($fell(flash_reset_n_ff) |-> (!flash_reset_n_ff) [*8]
      ##1 (!flash_reset_n_ff) [*8] ##1 (!flash_reset_n_ff) [*4])
    else $error("restore pulse short");
  a_restore_recover:
    assert property ($rose(flash_reset_n_ff) |-> flash_ce_n_ff [*3])
    else $error("read too soon after restore");
  a_busy_sync:
    assert property ((!ready_busy_out) [*4] |-> dev_busy_ff)
    else $error("busy not seen");
  a_restore_done:
    assert property (rs_take |-> ##[21:DONE_MAX] restore_done_ff)
    else $error("restore never done");
endmodule
bind fpr_host fpr_host_properties #(.READY_CYC(READY_CYC))
  fpr_host_properties_inst (.core_clk(core_clk), .rst(rst),
  .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
  .req_restore(req_restore), .rsp_valid_ff(rsp_valid_ff),
  .restore_done_ff(restore_done_ff), .flash_ce_n_ff(flash_ce_n_ff),
  .flash_oe_n_ff(flash_oe_n_ff), .flash_we_n_ff(flash_we_n_ff),
  .flash_reset_n_ff(flash_reset_n_ff),
  .flash_dq_oe_lo_ff(flash_dq_oe_lo_ff), .dev_busy_ff(dev_busy_ff),
  .ready_busy_out(ready_busy_out));
`default_nettype wire

// ===== logic/fpr_host.v
`timescale 1ns/1ps
`default_nettype none
`include "fpr_defines.vh"

////////////////////////////////////////////////////////////////////////////
module fpr_host #(
  parameter READY_CYC = `FPR_CYC_UP(`FPR_READY_NS)
) (
  input wire core_clk,
  input wire rst,
  input wire top_boot,
  input wire byte_mode,
  input wire req_valid,
  output wire req_ready,
  input wire req_write,
  input wire req_restore,
  input wire [`FPR_AW-1:0] req_addr,
  input wire req_lsb,
  input wire [`FPR_DW-1:0] req_wdata,
  output reg rsp_valid_ff,
  output reg [`FPR_DW-1:0] rsp_rdata_ff,
  output reg [`FPR_SW-1:0] rsp_sector_ff,
  output reg restore_done_ff,
  output reg dev_busy_ff,
  output reg flash_ce_n_ff,
  output reg flash_oe_n_ff,
  output reg flash_we_n_ff,
  output reg flash_reset_n_ff,
  output reg flash_byte_n_ff,
  output reg [`FPR_AW-1:0] flash_addr_ff,
  input wire [`FPR_DW-1:0] flash_dq_in,
  output reg [`FPR_DW-1:0] flash_dq_out_ff,
  output reg flash_dq_oe_lo_ff,
  output reg flash_dq_oe_hi_ff,
  input wire ready_busy_out
);

  // Gate access is shorter than the read hold, so it needs no count
  localparam integer CYC_ACC = `FPR_CYC_UP(`FPR_ACC_NS);
  localparam integer CYC_CE = `FPR_CYC_UP(`FPR_CE_NS);
  localparam integer CYC_RD = (CYC_CE > CYC_ACC) ? CYC_CE : CYC_ACC;
  localparam integer CYC_WP = `FPR_CYC_UP(`FPR_WP_NS);
  localparam integer CYC_WPH = `FPR_CYC_UP(`FPR_WPH_NS);
  localparam integer CYC_RP = `FPR_CYC_UP(`FPR_RP_NS);
  localparam integer CYC_RH = `FPR_CYC_UP(`FPR_RH_NS);
  localparam integer CYC_READY = READY_CYC;
  localparam [`FPR_CW-1:0] N_RD = CYC_RD[`FPR_CW-1:0];
  localparam [`FPR_CW-1:0] N_WP = CYC_WP[`FPR_CW-1:0];
  localparam [`FPR_CW-1:0] N_WPH = CYC_WPH[`FPR_CW-1:0];
  localparam [`FPR_CW-1:0] N_RP = CYC_RP[`FPR_CW-1:0];
  localparam [`FPR_CW-1:0] N_RH = CYC_RH[`FPR_CW-1:0];
  localparam [`FPR_CW-1:0] N_READY = CYC_READY[`FPR_CW-1:0];
  localparam [`FPR_CW-1:0] CNT_ONE = {{(`FPR_CW-1){1'b0}}, 1'b1};

  localparam ST_IDLE = 3'h0;
  localparam ST_READ = 3'h1;
  localparam ST_WRLO = 3'h2;
  localparam ST_WRHI = 3'h3;
  localparam ST_RSTLO = 3'h4;
  localparam ST_RSTWAIT = 3'h5;
  localparam ST_RSTREC = 3'h6;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [`FPR_CW-1:0] cnt_ff;
  reg [`FPR_CW-1:0] nxt_cnt;
  reg rb_meta_ff;
  reg rb_sync_ff;
  reg [`FPR_DW-1:0] dq_meta_ff;
  reg [`FPR_DW-1:0] dq_sync_ff;
  reg top_meta_ff;
  reg top_sync_ff;
  reg byte_meta_ff;
  reg byte_sync_ff;
  wire [`FPR_SW-1:0] req_sector;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always @(posedge core_clk) begin
    if (rst) begin
      rb_meta_ff <= 1'b1;
      rb_sync_ff <= 1'b1;
      dq_meta_ff <= {`FPR_DW{1'b0}};
      dq_sync_ff <= {`FPR_DW{1'b0}};
      top_meta_ff <= 1'b0;
      top_sync_ff <= 1'b0;
      byte_meta_ff <= 1'b0;
      byte_sync_ff <= 1'b0;
    end else begin
      rb_meta_ff <= ready_busy_out;
      rb_sync_ff <= rb_meta_ff;
      dq_meta_ff <= flash_dq_in;
      dq_sync_ff <= dq_meta_ff;
      // Straps are board pins too and may move while the clock runs
      top_meta_ff <= top_boot;
      top_sync_ff <= top_meta_ff;
      byte_meta_ff <= byte_mode;
      byte_sync_ff <= byte_meta_ff;
    end
  end

  // Layout chosen by a static strap pin, not by software
  fpr_sector_dec u_dec (
    .top_boot(top_sync_ff),
    .addr(req_addr),
    .sector(req_sector)
  );

  assign req_ready = (state_ff == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    if (cnt_ff != {`FPR_CW{1'b0}}) begin
      nxt_cnt = cnt_ff - CNT_ONE;
    end
    case (state_ff)
      ST_IDLE: begin
        if (req_valid && req_restore) begin
          nxt_state = ST_RSTLO;
          nxt_cnt = N_RP;
        end else if (req_valid && req_write) begin
          nxt_state = ST_WRLO;
          nxt_cnt = N_WP;
        end else if (req_valid) begin
          // Standby or sleep exit both cost the full select time
          nxt_state = ST_READ;
          nxt_cnt = N_RD;
        end
      end
      ST_READ: begin
        if (cnt_ff == {`FPR_CW{1'b0}}) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WRLO: begin
        if (cnt_ff == {`FPR_CW{1'b0}}) begin
          nxt_state = ST_WRHI;
          nxt_cnt = N_WPH;
        end
      end
      ST_WRHI: begin
        if (cnt_ff == {`FPR_CW{1'b0}}) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RSTLO: begin
        if (cnt_ff == {`FPR_CW{1'b0}}) begin
          nxt_state = ST_RSTWAIT;
          nxt_cnt = N_READY;
        end
      end
      ST_RSTWAIT: begin
        // Busy level means an embedded job was cut; idle ends sooner
        if (rb_sync_ff || cnt_ff == {`FPR_CW{1'b0}}) begin
          nxt_state = ST_RSTREC;
          nxt_cnt = N_RH;
        end
      end
      ST_RSTREC: begin
        if (cnt_ff == {`FPR_CW{1'b0}}) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= {`FPR_CW{1'b0}};
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; deselect between cycles puts the device in standby
  always @(posedge core_clk) begin
    if (rst) begin
      flash_ce_n_ff <= 1'b1;
      flash_oe_n_ff <= 1'b1;
      flash_we_n_ff <= 1'b1;
      flash_reset_n_ff <= 1'b1;
      flash_byte_n_ff <= 1'b1;
      flash_addr_ff <= {`FPR_AW{1'b0}};
      flash_dq_out_ff <= {`FPR_DW{1'b0}};
      flash_dq_oe_lo_ff <= 1'b0;
      flash_dq_oe_hi_ff <= 1'b0;
    end else begin
      flash_byte_n_ff <= ~byte_sync_ff;
      flash_ce_n_ff <= ~(nxt_state == ST_READ || nxt_state == ST_WRLO);
      // Gate held high except while reading so the bus never fights
      flash_oe_n_ff <= ~(nxt_state == ST_READ);
      flash_we_n_ff <= ~(nxt_state == ST_WRLO);
      flash_reset_n_ff <= ~(nxt_state == ST_RSTLO);
      if (state_ff == ST_IDLE && req_valid && !req_restore) begin
        // Address stays put afterwards; device may sleep, data kept
        flash_addr_ff <= req_addr;
        flash_dq_out_ff <= req_wdata;
        if (byte_sync_ff) begin
          flash_dq_out_ff[`FPR_DW-1] <= req_lsb;
        end
      end
      flash_dq_oe_lo_ff <= (nxt_state == ST_WRLO || nxt_state == ST_WRHI);
      // Bit 15 becomes the extra address pin in byte mode
      flash_dq_oe_hi_ff <= byte_sync_ff ||
        (nxt_state == ST_WRLO || nxt_state == ST_WRHI);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answers; poll reads are plain reads with status on low byte
  always @(posedge core_clk) begin
    if (rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= {`FPR_DW{1'b0}};
      rsp_sector_ff <= {`FPR_SW{1'b0}};
      restore_done_ff <= 1'b0;
      dev_busy_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= 1'b0;
      restore_done_ff <= 1'b0;
      dev_busy_ff <= ~rb_sync_ff;
      if (state_ff == ST_IDLE && req_valid) begin
        rsp_sector_ff <= req_sector;
      end
      // Sample at count end: pins caught 3 cycles after strobe, then two sync stages; no read during restore
      if (state_ff == ST_READ && cnt_ff == {`FPR_CW{1'b0}}) begin
        rsp_valid_ff <= 1'b1;
        rsp_rdata_ff <= dq_sync_ff;
        if (byte_sync_ff) begin
          rsp_rdata_ff <= {{`FPR_LANE_W{1'b0}}, dq_sync_ff[`FPR_LANE_W-1:0]};
        end
      end
      if (state_ff == ST_RSTREC && cnt_ff == {`FPR_CW{1'b0}}) begin
        // Device is back in array read; caller must reissue jobs
        restore_done_ff <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== logic/fpr_sector_dec.v
`timescale 1ns/1ps
`default_nettype none
`include "fpr_defines.vh"

module fpr_sector_dec (
  input wire top_boot,
  input wire [`FPR_AW-1:0] addr,
  output reg [`FPR_SW-1:0] sector
);

  wire [3:0] nib;
  assign nib = addr[`FPR_SEC_HI:`FPR_SEC_LO];

  // Only the 64 KB boundary nibble at the boot end needs the fine bits
  always @* begin
    sector = `FPR_SEC_TOP_BOOT;
    if (top_boot) begin
      if (nib != `FPR_NIB_ALL) begin
        sector = {1'b0, nib};
      end else if (!addr[`FPR_SEC_HALF_BIT]) begin
        sector = `FPR_SEC_TOP_BOOT;
      end else if (!addr[`FPR_SEC_QTR_BIT]) begin
        sector = `FPR_SEC_TOP_8K + {4'h0, addr[`FPR_SEC_EIGHTH_BIT]};
      end else begin
        sector = `FPR_SEC_TOP_16K;
      end
    end else begin
      if (nib != `FPR_NIB_NONE) begin
        sector = `FPR_SEC_BOT_BASE + {1'b0, nib};
      end else if (addr[`FPR_SEC_HALF_BIT]) begin
        sector = `FPR_SEC_BOT_32K;
      end else if (addr[`FPR_SEC_QTR_BIT]) begin
        sector = `FPR_SEC_BOT_8K + {4'h0, addr[`FPR_SEC_EIGHTH_BIT]};
      end else begin
        sector = `FPR_SEC_BOT_16K;
      end
    end
  end

endmodule
`default_nettype wire

// ===== shared/fpr_defines.vh
`ifndef FPR_DEFINES_VH
`define FPR_DEFINES_VH

// Clock rate and pin timing, in ns as printed, and as core_clk cycles
`define FPR_CLK_NS 25
`define FPR_ACC_NS 90
`define FPR_CE_NS 90
`define FPR_OE_NS 35
`define FPR_WP_NS 35
`define FPR_WPH_NS 30
`define FPR_RP_NS 500
`define FPR_RH_NS 50
`define FPR_READY_NS 20000
`define FPR_SLEEP_EXTRA_NS 30
// Least times round up
`define FPR_CYC_UP(ns) (((ns) + `FPR_CLK_NS - 1) / `FPR_CLK_NS)

// Bus widths
`define FPR_AW 19
`define FPR_DW 16
`define FPR_SW 5
`define FPR_CW 16

// Sector decode fields
`define FPR_SEC_HI 18
`define FPR_SEC_LO 15
`define FPR_SEC_TOP_BOOT 5'h0F
`define FPR_SEC_TOP_16K 5'h12
`define FPR_SEC_TOP_8K 5'h10
`define FPR_SEC_BOT_8K 5'h01
`define FPR_SEC_BOT_32K 5'h03
`define FPR_SEC_BOT_BASE 5'h03
`define FPR_NIB_ALL 4'hF
`define FPR_NIB_NONE 4'h0
`define FPR_SEC_BOT_16K 5'h00
// Fine address bits that split the boot-end 64 KB region
`define FPR_SEC_HALF_BIT 14
`define FPR_SEC_QTR_BIT 13
`define FPR_SEC_EIGHTH_BIT 12
// Width of the byte-mode data lane
`define FPR_LANE_W 8

`endif
